// ===== src/vdac_addr_count.sv
// Function
// - four independent channels with identical register sets
// - peripheral transfers use single-address cycles with byte operands
// - idle channels may do dual-address memory copies, byte or word
// - unchained, continue, array-chained and linked-chained styles supported
// - address registers are 32 bits, only low 24 drive the bus
// - top eight bus address bits come from a page register
// - memory address register addresses memory on every transfer
// - continue: base address copied into memory address, next block starts
// - chained: table entry fetched into memory address before data moves
// - dual-address: source and destination cycles, operand held between
// - single-address: peripheral selected by acknowledge, one bus cycle
// - dual-address uses memory and device address as source/destination
// - software loads operand count; decremented once per operand
// - count zero with no more blocks sets operation-complete status
// - continue: base counter loaded into memory counter at block end
// - array: base counter counts blocks left; linked ignores it
// - registers decoded from board base; unused locations reserved
// - peripheral raises request, controller answers with acknowledge
`timescale 1ns/1ps
`default_nettype none
module vdac_addr_count (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [vdac_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  output var  vdac_pkg::vdac_bus_t       mem_bus,
  input  wire logic                      mem_done,
  input  wire logic [15:0]               mem_rdata,
  input  wire logic [vdac_pkg::NUM_PORT-1:0] dev_req,
  output logic      [vdac_pkg::NUM_PORT-1:0] dev_ack,
  output logic                           irq
);
  import vdac_pkg::*;

  typedef struct packed {
    vdac_ch_t [NUM_CH-1:0]  ch;
    vdac_state_t            state;
    logic [1:0]             cur;
    logic [2:0]             fidx;
    logic [15:0]            hold;
    vdac_bus_t              bus;
    logic [NUM_PORT-1:0]    ack;
    logic [7:0]             page;
    logic [NUM_CH-1:0]      mask;
    logic [31:0]            prdata;
    logic                   pslverr;
  } vdac_st_t;

  vdac_st_t          st_q;
  vdac_st_t          st_d;
  logic [NUM_CH-1:0] rdy;
  logic [NUM_CH-1:0] cmp;

  ////////////////////////////////////////////////////////////////////////////
  // per-channel service readiness
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    assign rdy[i] = st_q.ch[i].active &
                    (st_q.ch[i].need_fetch | st_q.ch[i].ctrl.dual |
                     (st_q.ch[i].memory_transfer_counter == '0) |
                     dev_req[st_q.ch[i].ctrl.port]);
    assign cmp[i] = st_q.ch[i].complete;
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic vdac_ch_t finish(input vdac_ch_t c);
    vdac_ch_t r;
    r = c;
    r.active     = 1'b0;
    r.complete   = 1'b1;
    r.need_fetch = 1'b0;
    return r;
  endfunction : finish

  function automatic vdac_ch_t blk_end(input vdac_ch_t c);
    vdac_ch_t r;
    r = c;
    case (c.ctrl.style)
      STY_CONTINUE: begin
        if (c.base_transfer_counter != '0) begin
          r.memory_address_reg      = c.base_address_reg;
          r.memory_transfer_counter = c.base_transfer_counter;
          r.base_transfer_counter   = '0;
        end else begin
          r = finish(c);
        end
      end
      STY_ARRAY: begin
        if (c.base_transfer_counter != '0) begin
          r.need_fetch = 1'b1;
        end else begin
          r = finish(c);
        end
      end
      STY_LINKED: begin
        if (c.base_address_reg != '0) begin
          r.need_fetch = 1'b1;
        end else begin
          r = finish(c);
        end
      end
      default: begin
        r = finish(c);
      end
    endcase
    return r;
  endfunction : blk_end

  function automatic vdac_ch_t step(input vdac_ch_t c);
    vdac_ch_t    r;
    logic [31:0] sz;
    r  = c;
    sz = (c.ctrl.dual & c.ctrl.word) ? STEP_WORD : STEP_BYTE;
    r.memory_address_reg = c.memory_address_reg + sz;
    if (c.ctrl.dual) begin
      r.device_address_reg = c.device_address_reg + sz;
    end
    r.memory_transfer_counter = c.memory_transfer_counter - 16'h1;
    if (r.memory_transfer_counter == '0) begin
      r = blk_end(r);
    end
    return r;
  endfunction : step

  function automatic logic [31:0] bus_addr(input logic [7:0]  pg,
                                           input logic [31:0] a);
    return {pg, a[LOW_ADDR_W-1:0]};
  endfunction : bus_addr

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    vdac_ch_t   w;
    vdac_ctrl_t wc;
    logic       glb;
    logic [1:0] ci;
    logic [2:0] ri;
    logic       found;
    logic [1:0] sel;
    logic       last;
    st_d  = st_q;
    w     = st_q.ch[st_q.cur];
    wc    = vdac_ctrl_t'(pwdata[CTL_FIELD_LSB +: $bits(vdac_ctrl_t)]);
    glb   = paddr[GLB_BIT];
    ci    = paddr[CH_LSB +: 2];
    ri    = paddr[REG_LSB +: 3];
    found = 1'b0;
    sel   = '0;
    last  = 1'b0;

    // apb setup phase: latch read data and error for the access phase
    if (psel & ~penable) begin
      st_d.prdata  = '0;
      st_d.pslverr = 1'b0;
      if (glb) begin
        if (ci != '0) begin
          st_d.pslverr = 1'b1;
        end else begin
          case (ri)
            GREG_PAGE: st_d.prdata[7:0]        = st_q.page;
            GREG_IRQ:  st_d.prdata[NUM_CH-1:0] = cmp;
            GREG_MASK: st_d.prdata[NUM_CH-1:0] = st_q.mask;
            default:   st_d.pslverr            = 1'b1;
          endcase
        end
      end else begin
        case (ri)
          REG_CTRL: begin
            st_d.prdata[CTL_START_BIT] = st_q.ch[ci].active;
            st_d.prdata[CTL_FIELD_LSB +: $bits(vdac_ctrl_t)] = st_q.ch[ci].ctrl;
          end
          REG_STATUS: begin
            st_d.prdata[STS_COMPLETE] = st_q.ch[ci].complete;
            st_d.prdata[STS_ACTIVE]   = st_q.ch[ci].active;
          end
          REG_MEM_ADDR: st_d.prdata = st_q.ch[ci].memory_address_reg;
          REG_DEV_ADDR: st_d.prdata = st_q.ch[ci].device_address_reg;
          REG_BAR: st_d.prdata = st_q.ch[ci].base_address_reg;
          REG_MTC: st_d.prdata[15:0] = st_q.ch[ci].memory_transfer_counter;
          REG_BTC: st_d.prdata[15:0] = st_q.ch[ci].base_transfer_counter;
          default: st_d.pslverr = 1'b1;
        endcase
      end
    end

    // apb write, taken in the access phase
    if (psel & penable & pwrite) begin
      if (glb) begin
        if (ci == '0) begin
          case (ri)
            GREG_PAGE: st_d.page = pwdata[7:0];
            GREG_IRQ: begin
              for (int i = 0; i < NUM_CH; i++) begin
                if (pwdata[i]) begin
                  st_d.ch[i].complete = 1'b0;
                end
              end
            end
            GREG_MASK: st_d.mask = pwdata[NUM_CH-1:0];
            default: ;
          endcase
        end
      end else begin
        case (ri)
          REG_CTRL: begin
            // configuration is frozen while the channel runs
            if (~st_q.ch[ci].active) begin
              st_d.ch[ci].ctrl = wc;
              if (pwdata[CTL_START_BIT]) begin
                st_d.ch[ci].active     = 1'b1;
                st_d.ch[ci].need_fetch = (wc.style == STY_ARRAY) |
                                         (wc.style == STY_LINKED);
                if ((wc.style == STY_ARRAY) &&
                    (st_q.ch[ci].base_transfer_counter == '0)) begin
                  st_d.ch[ci] = finish(st_d.ch[ci]);
                end
              end
            end
          end
          REG_STATUS: begin
            if (pwdata[STS_COMPLETE]) begin
              st_d.ch[ci].complete = 1'b0;
            end
          end
          REG_MEM_ADDR: st_d.ch[ci].memory_address_reg = pwdata;
          REG_DEV_ADDR: st_d.ch[ci].device_address_reg = pwdata;
          REG_BAR: st_d.ch[ci].base_address_reg        = pwdata;
          REG_MTC: st_d.ch[ci].memory_transfer_counter = pwdata[15:0];
          REG_BTC: st_d.ch[ci].base_transfer_counter   = pwdata[15:0];
          default: ;
        endcase
      end
    end

    // engine: one shared bus master, lowest channel first
    w = st_d.ch[st_q.cur];
    case (st_q.state)
      ST_IDLE: begin
        for (int i = NUM_CH - 1; i >= 0; i--) begin
          if (rdy[i]) begin
            found = 1'b1;
            sel   = 2'(i);
          end
        end
        if (found) begin
          st_d.cur = sel;
          w = st_d.ch[sel];
          if (w.need_fetch) begin
            st_d.fidx  = '0;
            st_d.state = ST_FETCH;
          end else if (w.memory_transfer_counter == '0) begin
            w = blk_end(w);
          end else if (w.ctrl.dual) begin
            st_d.state = ST_SRC;
          end else begin
            st_d.state = ST_FLY;
          end
          st_d.ch[sel] = w;
        end
      end
      ST_FETCH: begin
        if (~st_q.bus.req) begin
          st_d.bus.req   = 1'b1;
          st_d.bus.write = 1'b0;
          st_d.bus.word  = 1'b1;
          st_d.bus.flyby = 1'b0;
          st_d.bus.addr  = bus_addr(st_q.page, w.base_address_reg +
                                    (32'(st_q.fidx) << 1));
        end else if (mem_done) begin
          st_d.bus.req = 1'b0;
          case (st_q.fidx)
            3'h1: w.memory_address_reg = {st_q.hold, mem_rdata};
            FIDX_ARRAY_LAST: w.memory_transfer_counter = mem_rdata;
            FIDX_LINK_LAST:  w.base_address_reg = {st_q.hold, mem_rdata};
            default: st_d.hold = mem_rdata;
          endcase
          last = (w.ctrl.style == STY_ARRAY) ? (st_q.fidx == FIDX_ARRAY_LAST) :
                                               (st_q.fidx == FIDX_LINK_LAST);
          if (last) begin
            w.need_fetch = 1'b0;
            if (w.ctrl.style == STY_ARRAY) begin
              w.base_address_reg      = w.base_address_reg + ARRAY_ENTRY;
              w.base_transfer_counter = w.base_transfer_counter - 16'h1;
            end
            st_d.state = ST_IDLE;
          end else begin
            st_d.fidx = st_q.fidx + 3'h1;
          end
        end
        st_d.ch[st_q.cur] = w;
      end
      ST_FLY: begin
        if (~st_q.bus.req) begin
          st_d.bus.req   = 1'b1;
          st_d.bus.write = w.ctrl.dir;
          st_d.bus.word  = 1'b0;
          st_d.bus.flyby = 1'b1;
          st_d.bus.addr  = bus_addr(st_q.page, w.memory_address_reg);
          st_d.ack[w.ctrl.port] = 1'b1;
        end else if (mem_done) begin
          st_d.bus.req = 1'b0;
          st_d.ack     = '0;
          w = step(w);
          st_d.ch[st_q.cur] = w;
          st_d.state = ST_IDLE;
        end
      end
      ST_SRC: begin
        if (~st_q.bus.req) begin
          st_d.bus.req   = 1'b1;
          st_d.bus.write = 1'b0;
          st_d.bus.word  = w.ctrl.word;
          st_d.bus.flyby = 1'b0;
          st_d.bus.addr  = bus_addr(st_q.page, w.ctrl.dir ?
                                    w.device_address_reg :
                                    w.memory_address_reg);
        end else if (mem_done) begin
          st_d.bus.req = 1'b0;
          st_d.hold    = mem_rdata;
          st_d.state   = ST_DST;
        end
      end
      ST_DST: begin
        if (~st_q.bus.req) begin
          st_d.bus.req   = 1'b1;
          st_d.bus.write = 1'b1;
          st_d.bus.word  = w.ctrl.word;
          st_d.bus.flyby = 1'b0;
          st_d.bus.wdata = st_q.hold;
          st_d.bus.addr  = bus_addr(st_q.page, w.ctrl.dir ?
                                    w.memory_address_reg :
                                    w.device_address_reg);
        end else if (mem_done) begin
          st_d.bus.req = 1'b0;
          w = step(w);
          st_d.ch[st_q.cur] = w;
          st_d.state = ST_IDLE;
        end
      end
      default: begin
        st_d.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (~presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata  = st_q.prdata;
  assign pready  = 1'b1;
  assign pslverr = st_q.pslverr;
  assign mem_bus = st_q.bus;
  assign dev_ack = st_q.ack;
  assign irq     = |(cmp & st_q.mask);

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  a_page_top: assert property (@(posedge pclk) disable iff (~presetn)
    $rose(mem_bus.req) |-> mem_bus.addr[31:24] == $past(st_q.page))
    else $error("bus address top byte differs from page");

  a_req_hold: assert property (@(posedge pclk) disable iff (~presetn)
    mem_bus.req & ~mem_done |=> mem_bus.req & $stable(mem_bus.addr))
    else $error("bus request dropped or changed before done");

  a_fly_byte: assert property (@(posedge pclk) disable iff (~presetn)
    mem_bus.req & mem_bus.flyby |-> ~mem_bus.word)
    else $error("single-address cycle with word operand");

  a_ack_fly: assert property (@(posedge pclk) disable iff (~presetn)
    (dev_ack != '0) |-> mem_bus.req & mem_bus.flyby & $onehot(dev_ack))
    else $error("acknowledge outside single-address cycle");

  a_dual_two: assert property (@(posedge pclk) disable iff (~presetn)
    st_q.state == ST_SRC && mem_bus.req && mem_done |=>
      st_q.state == ST_DST ##1 mem_bus.req && mem_bus.write)
    else $error("source cycle not followed by destination write");

  a_mtc_dec: assert property (@(posedge pclk) disable iff (~presetn)
    st_q.state == ST_FLY && mem_bus.req && mem_done &&
    st_q.ch[st_q.cur].memory_transfer_counter > 16'h1 &&
    !(psel && pwrite) |=>
      st_q.ch[st_q.cur].memory_transfer_counter ==
      $past(st_q.ch[st_q.cur].memory_transfer_counter) - 16'h1)
    else $error("transfer counter did not decrement by one");

  a_addr_step: assert property (@(posedge pclk) disable iff (~presetn)
    st_q.state == ST_FLY && mem_bus.req && mem_done && !(psel && pwrite) &&
    !(st_q.ch[st_q.cur].ctrl.style == STY_CONTINUE &&
      st_q.ch[st_q.cur].memory_transfer_counter == 16'h1 &&
      st_q.ch[st_q.cur].base_transfer_counter != '0) |=>
      st_q.ch[st_q.cur].memory_address_reg ==
      $past(st_q.ch[st_q.cur].memory_address_reg) + STEP_BYTE)
    else $error("memory address did not advance by one byte");

  a_cont_reload: assert property (@(posedge pclk) disable iff (~presetn)
    st_q.state == ST_FLY && mem_bus.req && mem_done && !(psel && pwrite) &&
    st_q.ch[st_q.cur].ctrl.style == STY_CONTINUE &&
    st_q.ch[st_q.cur].memory_transfer_counter == 16'h1 &&
    st_q.ch[st_q.cur].base_transfer_counter != '0 |=>
      st_q.ch[st_q.cur].memory_address_reg ==
      $past(st_q.ch[st_q.cur].base_address_reg))
    else $error("continue did not reload memory address from base");

  a_done_sets: assert property (@(posedge pclk) disable iff (~presetn)
    $rose(cmp[st_q.cur]) |-> $past(st_q.ch[st_q.cur].active) &&
                             !st_q.ch[st_q.cur].active)
    else $error("complete set without ending an active channel");

endmodule : vdac_addr_count
`default_nettype wire

// ===== src/vdac_pkg.sv
package vdac_pkg;

  localparam int NUM_CH   = 4;
  localparam int NUM_PORT = 2;

  // apb address layout: paddr[7] selects the global block
  localparam int ADDR_W  = 8;
  localparam int GLB_BIT = 7;
  localparam int CH_LSB  = 5;
  localparam int REG_LSB = 2;

  // per-channel word index
  localparam logic [2:0] REG_CTRL     = 3'h0;
  localparam logic [2:0] REG_STATUS   = 3'h1;
  localparam logic [2:0] REG_MEM_ADDR = 3'h2;
  localparam logic [2:0] REG_DEV_ADDR = 3'h3;
  localparam logic [2:0] REG_BAR      = 3'h4;
  localparam logic [2:0] REG_MTC      = 3'h5;
  localparam logic [2:0] REG_BTC      = 3'h6;

  // global word index
  localparam logic [2:0] GREG_PAGE = 3'h0;
  localparam logic [2:0] GREG_IRQ  = 3'h1;
  localparam logic [2:0] GREG_MASK = 3'h2;

  // control and status bit positions
  localparam int CTL_START_BIT = 0;
  localparam int CTL_FIELD_LSB = 1;
  localparam int STS_COMPLETE  = 0;
  localparam int STS_ACTIVE    = 1;

  // bus address split
  localparam int LOW_ADDR_W = 24;

  localparam logic [31:0] STEP_BYTE   = 32'h1;
  localparam logic [31:0] STEP_WORD   = 32'h2;
  localparam logic [31:0] ARRAY_ENTRY = 32'h6;
  localparam logic [2:0]  FIDX_ARRAY_LAST = 3'h2;
  localparam logic [2:0]  FIDX_LINK_LAST  = 3'h4;

  typedef enum logic [1:0] {
    STY_UNCHAINED = 2'b00,
    STY_CONTINUE  = 2'b01,
    STY_ARRAY     = 2'b10,
    STY_LINKED    = 2'b11
  } vdac_style_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FETCH = 3'b001,
    ST_FLY   = 3'b010,
    ST_SRC   = 3'b011,
    ST_DST   = 3'b100
  } vdac_state_t;

  typedef struct packed {
    logic        port;
    logic        dir;
    logic        word;
    logic        dual;
    vdac_style_t style;
  } vdac_ctrl_t;

  typedef struct packed {
    logic        active;
    logic        complete;
    logic        need_fetch;
    vdac_ctrl_t  ctrl;
    logic [31:0] memory_address_reg;
    logic [31:0] device_address_reg;
    logic [31:0] base_address_reg;
    logic [15:0] memory_transfer_counter;
    logic [15:0] base_transfer_counter;
  } vdac_ch_t;

  typedef struct packed {
    logic        req;
    logic        write;
    logic        word;
    logic        flyby;
    logic [31:0] addr;
    logic [15:0] wdata;
  } vdac_bus_t;

endpackage : vdac_pkg

// ===== verif/vdac_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module vdac_mem_model (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire vdac_pkg::vdac_bus_t mem_bus,
  input  wire logic [1:0]          lat,
  output logic                     mem_done,
  output logic [15:0]              mem_rdata
);
  import vdac_pkg::*;
  logic [15:0] mem [logic [31:0]];
  vdac_bus_t   log_q [$];
  int          wait_n;
  ////////////////////////////////////////////////////////////////////////////
  // one bus cycle per request, answered after a random wait
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_done <= 1'b0;
      mem_rdata <= 16'h0;
      wait_n = 0;
    end else if ((mem_bus.req & mem_done) === 1'b1) begin
      log_q.push_back(mem_bus);
      if (mem_bus.write && !mem_bus.flyby) mem[mem_bus.addr] = mem_bus.wdata;
      mem_done <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_n = 0;
    end else if (mem_bus.req === 1'b1 && wait_n >= lat) begin
      mem_done <= 1'b1;
      mem_rdata <= mem.exists(mem_bus.addr) ? mem[mem_bus.addr] : ~mem_bus.addr[15:0];
    end else begin
      mem_done <= 1'b0;
      // released data never holds its last value
      mem_rdata <= ~mem_rdata;
      wait_n = wait_n + 32'(mem_bus.req === 1'b1);
    end
  end
endmodule : vdac_mem_model
`default_nettype wire

// ===== verif/vdac_addr_count_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin mismatches++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module vdac_addr_count_bench;
  import vdac_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, mem_done, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd, seed;
  logic [15:0]       mem_rdata;
  logic [1:0]        dev_req, dev_ack, lat;
  logic [7:0]        page;
  vdac_bus_t         mem_bus;
  vdac_bus_t         exp_q [$];
  int                mismatches, n_checks, cycles, port_n;

  vdac_addr_count u_vdac_addr_count (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_bus(mem_bus), .mem_done(mem_done),
    .mem_rdata(mem_rdata), .dev_req(dev_req), .dev_ack(dev_ack), .irq(irq));
  vdac_mem_model u_vdac_mem_model (.pclk(pclk), .presetn(presetn), .mem_bus(mem_bus),
    .lat(lat), .mem_done(mem_done), .mem_rdata(mem_rdata));
  ////////////////////////////////////////////////////////////////////////////
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    lat <= 2'($random(seed));
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      close_out();
    end
  end
  always @(posedge pclk) begin
    if ((mem_bus.req & mem_done & mem_bus.flyby) === 1'b1) begin
      `CHK("dev_ack", 2'(1 << port_n), dev_ack)
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("register", e, rd)
  endtask : rd_chk

  function automatic logic [31:0] bus_a(input logic [31:0] a);
    return {page, a[23:0]};
  endfunction : bus_a

  task automatic exp_cyc(input logic wr, wd, fb, input logic [31:0] a, input logic [15:0] v);
    exp_q.push_back(vdac_bus_t'{1'b1, wr, wd, fb, bus_a(a), v});
  endtask : exp_cyc

  task automatic tbl(input logic [31:0] b, m, input logic [15:0] c, input logic [31:0] lk);
    logic [15:0] w [5];
    w = '{m[31:16], m[15:0], c, lk[31:16], lk[15:0]};
    foreach (w[k]) u_vdac_mem_model.mem[bus_a(b + 32'(2 * k))] = w[k];
  endtask : tbl

  // reference of one channel operation: expected bus cycles and final address
  task automatic ref_run(input int st, c, t, input logic dual, word, dir,
                         input logic [31:0] m0, d, b, output logic [31:0] m);
    logic [31:0] s, a;
    bit          fetch, done;
    m = m0;
    fetch = st == 3 || (st == 2 && t != 0);
    done = st == 2 && t == 0;
    while (!done) begin
      if (fetch) begin
        for (int k = 0; k < (st == 3 ? 5 : 3); k++) exp_cyc(0, 1, 0, b + 32'(2 * k), 0);
        m = {u_vdac_mem_model.mem[bus_a(b)], u_vdac_mem_model.mem[bus_a(b + 2)]};
        c = int'(u_vdac_mem_model.mem[bus_a(b + 4)]);
        if (st == 2) begin
          b += 6;
          t--;
        end else begin
          b = {u_vdac_mem_model.mem[bus_a(b + 6)], u_vdac_mem_model.mem[bus_a(b + 8)]};
        end
      end
      for (; c > 0; c--) begin
        if (!dual) begin
          exp_cyc(dir, 0, 1, m, 0);
        end else begin
          s = dir ? d : m;
          a = dir ? m : d;
          if (!u_vdac_mem_model.mem.exists(bus_a(s)))
            u_vdac_mem_model.mem[bus_a(s)] = 16'($random(seed));
          exp_cyc(0, word, 0, s, 0);
          exp_cyc(1, word, 0, a, u_vdac_mem_model.mem[bus_a(s)]);
          d += word ? 32'h2 : 32'h1;
        end
        m += (dual && word) ? 32'h2 : 32'h1;
      end
      fetch = (st == 2 && t != 0) || (st == 3 && b != 0);
      done = st == 0 || (!fetch && !(st == 1 && t != 0));
      if (st == 1 && t != 0) begin
        m = b;
        c = t;
        t = 0;
      end
    end
  endtask : ref_run

  task automatic run(input int ch, st, c, t, input logic dual, word, dir, prt,
                     input logic [31:0] m0, d0, b0);
    logic [7:0]  cb;
    logic [31:0] mf;
    vdac_bus_t   e, g;
    int          n;
    cb = 8'(ch * 32);
    exp_q.delete();
    u_vdac_mem_model.log_q.delete();
    apb(1, cb + 8'h08, m0);
    apb(1, cb + 8'h0c, d0);
    apb(1, cb + 8'h10, b0);
    apb(1, cb + 8'h14, 32'(c));
    apb(1, cb + 8'h18, 32'(t));
    ref_run(st, c, t, dual, word, dir, m0, d0, b0, mf);
    port_n = int'(prt);
    if (!dual) dev_req[prt] <= 1'b1;
    apb(1, cb, {25'h0, prt, dir, word, dual, 2'(st), 1'b1});
    n = 0;
    do begin
      apb(0, 8'h84, 32'h0);
      n++;
    end while (rd[ch] !== 1'b1 && n < 400);
    dev_req <= 2'b00;
    `CHK("irq masked", 1'b0, irq)
    rd_chk(cb + 8'h04, 32'h1);
    rd_chk(cb + 8'h08, mf);
    rd_chk(cb + 8'h14, 32'h0);
    apb(1, 8'h88, 32'hf);
    rd_chk(8'h84, 32'(1) << ch);
    `CHK("irq", 1'b1, irq)
    if (ch % 2) apb(1, 8'h84, 32'(1) << ch);
    else apb(1, cb + 8'h04, 32'h1);
    rd_chk(8'h84, 32'h0);
    `CHK("irq cleared", 1'b0, irq)
    apb(1, 8'h88, 32'h0);
    `CHK("cycle count", exp_q.size(), u_vdac_mem_model.log_q.size())
    while (exp_q.size() > 0 && u_vdac_mem_model.log_q.size() > 0) begin
      e = exp_q.pop_front();
      g = u_vdac_mem_model.log_q.pop_front();
      if (e.flyby || !e.write) g.wdata = 16'h0;
      `CHK("bus cycle", e, g)
    end
  endtask : run
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] v;
    seed = 32'hd00a;
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    dev_req = 2'b00;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      rd_chk(8'(ch * 32 + 8), 32'h0);
      v = $random(seed);
      apb(1, 8'(ch * 32 + 8), v);
      rd_chk(8'(ch * 32 + 8), v);
      apb(1, 8'(ch * 32 + 20), 32'hffffffff);
      rd_chk(8'(ch * 32 + 20), 32'hffff);
      apb(0, 8'(ch * 32 + 28), 32'h0);
      `CHK("unmapped", 1'b1, err)
    end
    apb(1, 8'hc0, 32'h1);
    `CHK("unmapped", 1'b1, err)
    rd_chk(8'hc0, 32'h0);
    page = 8'($random(seed));
    apb(1, 8'h80, {24'h0, page});
    rd_chk(8'h80, {24'h0, page});
    run(0, 0, 5, 0, 0, 0, 0, 0, {v[31:24], 24'h001000}, 0, 0);
    run(1, 0, 3, 0, 0, 0, 1, 1, 32'h00fffffe, 0, 0);
    run(2, 0, 4, 0, 1, 1, 0, 0, 32'h2000, 32'h3000, 0);
    run(3, 0, 3, 0, 1, 0, 1, 0, 32'h4000, 32'h5001, 0);
    run(2, 1, 2, 3, 0, 0, 0, 1, 32'h6000, 0, 32'h7000);
    tbl(32'h8000, 32'hd000, 16'h2, 32'h0);
    tbl(32'h8006, 32'he000, 16'h1, 32'h0);
    run(3, 2, 0, 2, 0, 0, 1, 0, 0, 0, 32'h8000);
    run(0, 2, 0, 0, 1, 1, 0, 0, 32'h9000, 32'h9800, 32'h8000);
    tbl(32'ha000, 32'hb000, 16'h2, 32'ha010);
    tbl(32'ha010, 32'hc000, 16'h3, 32'h0);
    run(1, 3, 0, 0, 0, 0, 0, 1, 0, 0, 32'ha000);
    close_out();
  end
endmodule : vdac_addr_count_bench
`default_nettype wire
